/* dck_defines.svh */
// register offsets, field positions and reset values of the clock and tuner input setup block
`ifndef DCK_DEFINES_SVH
`define DCK_DEFINES_SVH

`define DCK_OFS_CLK_SRC     16'h0000
`define DCK_OFS_DIE_REV     16'h0023
`define DCK_OFS_SYS_DIV     16'h00a0
`define DCK_OFS_SMP_DIV     16'h00a1
`define DCK_OFS_LOOP_CTL    16'h00a2
`define DCK_OFS_REF_DIV     16'h00a3
`define DCK_OFS_SMP_MODE    16'h00e0
`define DCK_OFS_IF_SHIFT    16'h00e8
`define DCK_OFS_CH_SWAP     16'h0122
`define DCK_OFS_TUNE_EXTRA  16'h0123
`define DCK_OFS_TUNE_FIRST  16'h0129
`define DCK_OFS_TUNE_LAST   16'h012f
`define DCK_OFS_TIM_TOL     16'h0318
`define DCK_OFS_INV_STAT    16'h0444
`define DCK_OFS_INV_CTL     16'h0450
`define DCK_OFS_STR_CTL     16'h0641
`define DCK_OFS_STR_SAMPLE  16'h0642
`define DCK_OFS_STR_PIN     16'h0646

// loop control fields
`define DCK_LOOP_EN_BIT     7
`define DCK_LOOP_PRESC_BIT  6
`define DCK_LOOP_MULT_MSB   5
// sampling mode fields
`define DCK_MODE_ZIF_BIT    0
`define DCK_MODE_FOURFOLD_OVERSAMPLING_BIT   1
// inversion control fields
`define DCK_INV_MANUAL_BIT  0
`define DCK_INV_SET_BIT     1
// strength control fields
`define DCK_STR_EN_BIT      0
`define DCK_STR_START_BIT   1
`define DCK_STR_UPD_LSB     2
`define DCK_STR_UPD_MSB     5
`define DCK_STR_UPD_BASE    5

`define DCK_RST_BYTE        8'h00
`define DCK_DIE_REV_VAL     8'h01

`endif

/* dck_pkg.sv */
// types shared by the clock and tuner input setup block
package dck_pkg;

  typedef enum logic [1:0] {
    DCK_SRC_OFF,
    DCK_SRC_CRYSTAL,
    DCK_SRC_EXTERNAL,
    DCK_SRC_SPARE
  } dck_src_e;

  typedef logic [7:0]  dck_byte_t;
  typedef logic [9:0]  dck_div_t;
  typedef logic [11:0] dck_sample_t;

endpackage : dck_pkg

/* dck_tick_div.sv */
// programmable divider producing one-cycle enable ticks
`timescale 1ns/1ps
`default_nettype none
module dck_tick_div
  import dck_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire logic     ce,
  input  wire logic     run,
  input  wire dck_div_t divisor,
  output logic          tick
);

  dck_div_t cnt_r;

  // zero divisor means not yet programmed, no ticks
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      if (!run || divisor == '0)
      begin
        cnt_r <= '0;
        tick  <= 1'b0;
      end
      else if (cnt_r >= divisor - 10'h001)
      begin
        cnt_r <= '0;
        tick  <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r + 10'h001;
        tick  <= 1'b0;
      end
    end
  end

endmodule : dck_tick_div
`default_nettype wire

/* dck_pin_sync.sv */
// three-stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dck_pin_sync
#(
  parameter int W = 8
)
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] value
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      value <= '0;
    end
    else if (ce)
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        value <= s3_r;
    end
  end

endmodule : dck_pin_sync
`default_nettype wire

/* dck_clock_setup.sv */
// clock source, loop dividers, tuner input path and strength monitor
`timescale 1ns/1ps
`default_nettype none
`include "dck_defines.svh"
module dck_clock_setup
  import dck_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // clock control outputs
  output logic             standby,
  output logic      [1:0]  clk_source,
  output logic             loop_running,
  output logic      [2:0]  prescale_factor,
  output logic      [5:0]  loop_multiplier,
  output logic      [7:0]  ref_divider,
  output logic             sampling_tick,
  output logic             front_end_tick,
  output logic             system_tick,
  output logic      [7:0]  timing_tolerance_ppm,
  output logic      [63:0] converter_tuning,
  // converter samples and front-end output
  input  wire logic [11:0] conv_i_data,
  input  wire logic [11:0] conv_q_data,
  output logic      [11:0] fe_i_data,
  output logic      [11:0] fe_q_data,
  output logic             fe_valid,
  output logic      [7:0]  mix_phase,
  // cable spectral inversion
  input  wire logic        cable_mode,
  input  wire logic        inversion_detect,
  output logic             spectrum_invert,
  // strength pin, two-way
  input  wire logic        strength_pin_i,
  output logic             strength_pin_o,
  output logic             strength_pin_oe,
  input  wire logic [7:0]  strength_conv_data,
  output logic             strength_conv_on
);

  dck_src_e    src_r;
  dck_byte_t   sys_div_r;
  dck_byte_t   smp_div_r;
  dck_byte_t   loop_ctl_r;
  dck_byte_t   ref_div_r;
  dck_byte_t   smp_mode_r;
  dck_byte_t   if_shift_r;
  dck_byte_t   swap_r;
  dck_byte_t   tune_r [0:7];
  dck_byte_t   tim_tol_r;
  dck_byte_t   inv_ctl_r;
  dck_byte_t   inv_stat_r;
  dck_byte_t   str_ctl_r;
  dck_byte_t   str_pin_r;
  dck_byte_t   str_sample_r;
  dck_byte_t   rdata_nxt;
  logic        clocks_on;
  logic        mode_zif;
  logic        mode_fourfold_oversampling;
  dck_div_t    smp_divisor;
  dck_div_t    fe_divisor;
  dck_div_t    sys_divisor;
  logic        str_active;
  logic [20:0] str_cnt_r;
  logic [20:0] str_period;
  logic [7:0]  str_synced;
  logic [11:0] sel_i;
  logic [11:0] sel_q;
  logic [11:0] neg_i;
  logic [11:0] neg_q;
  logic        ref_out_r;
  logic [3:0]  upd_time;

  assign clocks_on    = (src_r != DCK_SRC_OFF);
  assign standby      = !clocks_on;
  assign clk_source   = src_r;
  assign loop_running = clocks_on && loop_ctl_r[`DCK_LOOP_EN_BIT];
  assign prescale_factor = loop_ctl_r[`DCK_LOOP_PRESC_BIT] ? 3'h4 : 3'h1;
  assign loop_multiplier = loop_ctl_r[`DCK_LOOP_MULT_MSB:0];
  assign ref_divider     = ref_div_r;
  assign timing_tolerance_ppm = tim_tol_r;
  assign mode_zif  = smp_mode_r[`DCK_MODE_ZIF_BIT];
  assign mode_fourfold_oversampling = smp_mode_r[`DCK_MODE_FOURFOLD_OVERSAMPLING_BIT];
  assign upd_time  = str_ctl_r[`DCK_STR_UPD_MSB:`DCK_STR_UPD_LSB];

  assign smp_divisor = {smp_div_r, 2'b00};
  // front end equal or double rate
  assign fe_divisor  = mode_fourfold_oversampling ? {smp_div_r, 2'b00} : {1'b0, smp_div_r, 1'b0};
  assign sys_divisor = {1'b0, sys_div_r, 1'b0};

  always_comb
  begin
    for (int k = 0; k < 8; k++)
      converter_tuning[k*8 +: 8] = tune_r[k];
  end

  dck_tick_div u_smp_div (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .run     (loop_running),
    .divisor (smp_divisor),
    .tick    (sampling_tick)
  );

  dck_tick_div u_fe_div (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .run     (loop_running),
    .divisor (fe_divisor),
    .tick    (front_end_tick)
  );

  dck_tick_div u_sys_div (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .run     (loop_running),
    .divisor (sys_divisor),
    .tick    (system_tick)
  );

  dck_pin_sync #(.W(8)) u_str_sync (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .pin   (strength_conv_data),
    .value (str_synced)
  );

  // register writes
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      src_r      <= DCK_SRC_OFF;
      sys_div_r  <= `DCK_RST_BYTE;
      smp_div_r  <= `DCK_RST_BYTE;
      loop_ctl_r <= `DCK_RST_BYTE;
      ref_div_r  <= `DCK_RST_BYTE;
      smp_mode_r <= `DCK_RST_BYTE;
      if_shift_r <= `DCK_RST_BYTE;
      swap_r     <= `DCK_RST_BYTE;
      tim_tol_r  <= `DCK_RST_BYTE;
      inv_ctl_r  <= `DCK_RST_BYTE;
      str_ctl_r  <= `DCK_RST_BYTE;
      str_pin_r  <= `DCK_RST_BYTE;
      for (int i = 0; i < 8; i++)
        tune_r[i] <= `DCK_RST_BYTE;
    end
    else if (ce && reg_wr)
    begin
      case (reg_addr)
        `DCK_OFS_CLK_SRC:    src_r      <= dck_src_e'(reg_wdata[1:0]);
        `DCK_OFS_SYS_DIV:    sys_div_r  <= reg_wdata;
        `DCK_OFS_SMP_DIV:    smp_div_r  <= reg_wdata;
        `DCK_OFS_LOOP_CTL:   loop_ctl_r <= reg_wdata;
        `DCK_OFS_REF_DIV:    ref_div_r  <= reg_wdata;
        `DCK_OFS_SMP_MODE:   smp_mode_r <= reg_wdata;
        `DCK_OFS_IF_SHIFT:   if_shift_r <= reg_wdata;
        `DCK_OFS_CH_SWAP:    swap_r     <= reg_wdata;
        `DCK_OFS_TUNE_EXTRA: tune_r[7]  <= reg_wdata;
        `DCK_OFS_TIM_TOL:    tim_tol_r  <= reg_wdata;
        `DCK_OFS_INV_CTL:    inv_ctl_r  <= reg_wdata;
        `DCK_OFS_STR_CTL:    str_ctl_r  <= reg_wdata;
        `DCK_OFS_STR_PIN:    str_pin_r  <= reg_wdata;
        default:
        begin
          if (reg_addr >= `DCK_OFS_TUNE_FIRST && reg_addr <= `DCK_OFS_TUNE_LAST)
            tune_r[reg_addr[2:0] - 3'h1] <= reg_wdata;
        end
      endcase
    end
  end

  // read decode
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `DCK_OFS_CLK_SRC:    rdata_nxt = {6'h00, src_r};
      `DCK_OFS_DIE_REV:    rdata_nxt = `DCK_DIE_REV_VAL;
      `DCK_OFS_SYS_DIV:    rdata_nxt = sys_div_r;
      `DCK_OFS_SMP_DIV:    rdata_nxt = smp_div_r;
      `DCK_OFS_LOOP_CTL:   rdata_nxt = loop_ctl_r;
      `DCK_OFS_REF_DIV:    rdata_nxt = ref_div_r;
      `DCK_OFS_SMP_MODE:   rdata_nxt = smp_mode_r;
      `DCK_OFS_IF_SHIFT:   rdata_nxt = if_shift_r;
      `DCK_OFS_CH_SWAP:    rdata_nxt = swap_r;
      `DCK_OFS_TUNE_EXTRA: rdata_nxt = tune_r[7];
      `DCK_OFS_TIM_TOL:    rdata_nxt = tim_tol_r;
      `DCK_OFS_INV_STAT:   rdata_nxt = inv_stat_r;
      `DCK_OFS_INV_CTL:    rdata_nxt = inv_ctl_r;
      `DCK_OFS_STR_CTL:    rdata_nxt = str_ctl_r;
      `DCK_OFS_STR_SAMPLE: rdata_nxt = str_sample_r;
      `DCK_OFS_STR_PIN:    rdata_nxt = str_pin_r;
      default:
      begin
        if (reg_addr >= `DCK_OFS_TUNE_FIRST && reg_addr <= `DCK_OFS_TUNE_LAST)
          rdata_nxt = tune_r[reg_addr[2:0] - 3'h1];
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_nxt;
    end
  end

  // converter selection and swap
  always_comb
  begin
    if (mode_zif)
    begin
      sel_i = swap_r[0] ? conv_q_data : conv_i_data;
      sel_q = swap_r[0] ? conv_i_data : conv_q_data;
    end
    else
    begin
      sel_i = swap_r[0] ? conv_q_data : conv_i_data;
      sel_q = 12'h000;
    end
  end

  assign neg_i = 12'h000 - sel_i;
  assign neg_q = 12'h000 - sel_q;

  // phase accumulator steps by shift word
  always_ff @(posedge clk)
  begin
    if (!rstn)
      mix_phase <= 8'h00;
    else if (ce)
    begin
      if (!loop_running)
        mix_phase <= 8'h00;
      else if (front_end_tick)
        mix_phase <= mix_phase + if_shift_r;
    end
  end

  // quadrant rotation of input by phase
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fe_i_data <= 12'h000;
      fe_q_data <= 12'h000;
      fe_valid  <= 1'b0;
    end
    else if (ce)
    begin
      fe_valid <= sampling_tick;
      if (sampling_tick)
      begin
        case (mix_phase[7:6])
          2'h0:
          begin
            fe_i_data <= sel_i;
            fe_q_data <= sel_q;
          end
          2'h1:
          begin
            fe_i_data <= sel_q;
            fe_q_data <= neg_i;
          end
          2'h2:
          begin
            fe_i_data <= neg_i;
            fe_q_data <= neg_q;
          end
          default:
          begin
            fe_i_data <= neg_q;
            fe_q_data <= sel_i;
          end
        endcase
      end
    end
  end

  assign spectrum_invert = cable_mode &&
                           (inv_ctl_r[`DCK_INV_MANUAL_BIT] ? inv_ctl_r[`DCK_INV_SET_BIT] : inversion_detect);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      inv_stat_r <= 8'h00;
    else if (ce)
    begin
      if (cable_mode && !inv_ctl_r[`DCK_INV_MANUAL_BIT])
        inv_stat_r <= {7'h00, inversion_detect};
    end
  end

  assign strength_pin_oe = str_pin_r[0] && clocks_on;
  assign strength_pin_o  = ref_out_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      ref_out_r <= 1'b0;
    else if (ce)
      ref_out_r <= clocks_on ? !ref_out_r : 1'b0;
  end

  // measuring needs input role, power, start
  assign str_active       = !str_pin_r[0] && str_ctl_r[`DCK_STR_EN_BIT] && str_ctl_r[`DCK_STR_START_BIT];
  assign strength_conv_on = !str_pin_r[0] && str_ctl_r[`DCK_STR_EN_BIT];
  assign str_period = 21'h000001 << ({1'b0, upd_time} + 5'(`DCK_STR_UPD_BASE));

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      str_cnt_r    <= 21'h000000;
      str_sample_r <= 8'h00;
    end
    else if (ce)
    begin
      if (!str_active)
        str_cnt_r <= 21'h000000;
      else if (system_tick)
      begin
        if (str_cnt_r >= str_period - 21'h000001)
        begin
          str_cnt_r    <= 21'h000000;
          str_sample_r <= str_synced;
        end
        else
          str_cnt_r <= str_cnt_r + 21'h000001;
      end
    end
  end

endmodule : dck_clock_setup
`default_nettype wire

/* dck_clock_setup_sva.sv */
// concurrent checks on the clock and tuner input setup ports
`timescale 1ns/1ps
`default_nettype none
module dck_clock_setup_sva
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic       reg_rd,
  input wire logic       reg_rvalid,
  input wire logic       standby,
  input wire logic [1:0] clk_source,
  input wire logic       loop_running,
  input wire logic [2:0] prescale_factor,
  input wire logic       sampling_tick,
  input wire logic       system_tick,
  input wire logic       fe_valid,
  input wire logic [7:0] mix_phase,
  input wire logic       cable_mode,
  input wire logic       spectrum_invert,
  input wire logic       strength_pin_o,
  input wire logic       strength_pin_oe,
  input wire logic       strength_conv_on
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_read_answer: assert property (reg_rd && ce |=> reg_rvalid)
    else $error("read not answered");
  chk_standby_src: assert property (standby == (clk_source == 2'h0))
    else $error("standby does not follow clock source");
  chk_presc_vals: assert property (prescale_factor == 3'h1 || prescale_factor == 3'h4)
    else $error("prescale factor out of set");
  chk_loop_gate: assert property (!loop_running ##1 !loop_running |-> !sampling_tick && !system_tick)
    else $error("tick while loop stopped");
  chk_tick_gap: assert property (sampling_tick && ce |=> !sampling_tick)
    else $error("sampling ticks too close");
  chk_fe_follow: assert property (sampling_tick && ce |=> fe_valid)
    else $error("front-end sample missing");
  chk_fe_cause: assert property (fe_valid |-> $past(sampling_tick))
    else $error("front-end sample without tick");
  chk_mix_idle: assert property (!loop_running ##1 !loop_running |-> mix_phase == 8'h00)
    else $error("mix phase not cleared");
  chk_inv_cable: assert property (spectrum_invert |-> cable_mode)
    else $error("inversion outside cable mode");
  chk_pin_dir: assert property (strength_pin_oe |-> !standby && !strength_conv_on)
    else $error("pin driven in wrong role");
  chk_ref_out: assert property (!standby && !$past(standby) && $past(ce) |-> strength_pin_o != $past(strength_pin_o))
    else $error("reference out not toggling");
endmodule : dck_clock_setup_sva

bind dck_clock_setup dck_clock_setup_sva u_sva (.clk(clk), .rstn(rstn), .ce(ce), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .standby(standby), .clk_source(clk_source), .loop_running(loop_running),
  .prescale_factor(prescale_factor), .sampling_tick(sampling_tick), .system_tick(system_tick),
  .fe_valid(fe_valid), .mix_phase(mix_phase), .cable_mode(cable_mode), .spectrum_invert(spectrum_invert),
  .strength_pin_o(strength_pin_o), .strength_pin_oe(strength_pin_oe), .strength_conv_on(strength_conv_on));
`default_nettype wire

/* dck_tuner_model.sv */
// tuner model giving changing converter samples and a steady strength level
`timescale 1ns/1ps
`default_nettype none
module dck_tuner_model
(
  input  wire logic        clk,
  input  wire logic [7:0]  level,
  output logic      [11:0] i_out,
  output logic      [11:0] q_out,
  output logic      [7:0]  strength_out
);
  logic [11:0] ph_r = 12'h000;
  always_ff @(posedge clk)
    ph_r <= ph_r + 12'h035;
  assign i_out        = ph_r;
  assign q_out        = ~ph_r ^ 12'h0a5;
  assign strength_out = level;
endmodule : dck_tuner_model
`default_nettype wire

/* dck_clock_setup_tb_top.sv */
// self-checking bench for the clock and tuner input setup block
`timescale 1ns/1ps
`default_nettype none
module dck_clock_setup_tb_top;
  logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, cable = 1'b0, det = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, lvl = 8'h00, rdata, tol, rdiv, mix, sdat;
  logic        rvalid, stby, run, st, ft, yt, fev, inv, po, poe, con;
  logic [1:0]  src;
  logic [2:0]  psc;
  logic [5:0]  mult;
  logic [63:0] tune;
  logic [11:0] ci, cq, fi, fq;
  logic [4:0]  c_t = 5'b11101, d_t = 5'b01011, e_t = 5'b10001;
  wire  [2:0]  ticks = {yt, ft, st};
  wire         pin = poe ? po : lvl[7];
  int          num_errors = 0, num_checks = 0;

  always #5 clk = ~clk;

  dck_tuner_model tuner (.clk(clk), .level(lvl), .i_out(ci), .q_out(cq), .strength_out(sdat));
  dck_clock_setup dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .standby(stby), .clk_source(src),
    .loop_running(run), .prescale_factor(psc), .loop_multiplier(mult), .ref_divider(rdiv),
    .sampling_tick(st), .front_end_tick(ft), .system_tick(yt), .timing_tolerance_ppm(tol),
    .converter_tuning(tune), .conv_i_data(ci), .conv_q_data(cq), .fe_i_data(fi), .fe_q_data(fq),
    .fe_valid(fev), .mix_phase(mix), .cable_mode(cable), .inversion_detect(det), .spectrum_invert(inv),
    .strength_pin_i(pin), .strength_pin_o(po), .strength_pin_oe(poe), .strength_conv_data(sdat),
    .strength_conv_on(con));

  task automatic cmp_v(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_v

  task automatic cmp_n(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_n

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic peek(input logic [15:0] a, output logic [7:0] got);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    cmp_v(rvalid, 1'b1);
    got = rdata;
  endtask : peek

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] g;
    peek(a, g);
    cmp_v(g, e);
  endtask : rd_reg

  task automatic period(input int s, input int e);
    int n;
    int p;
    int t;
    n = 0;
    p = 0;
    t = 0;
    for (int c = 0; c < 400 && t < 3; c++)
    begin
      @(posedge clk);
      n++;
      if (ticks[s])
      begin
        p = n;
        n = 0;
        t++;
      end
    end
    cmp_n(p, e);
  endtask : period

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    logic [11:0] a, b;
    logic [7:0]  m, g;
    int          n;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp_v({stby, poe}, 2'b10);
    rd_reg(16'h0000, 8'h00);
    rd_reg(16'h0023, 8'h01);
    wr_reg(16'h0023, 8'h5a);
    rd_reg(16'h0023, 8'h01);
    rd_reg(16'h0555, 8'h00);
    ce <= 1'b0;
    wr_reg(16'h00a3, 8'hff);
    ce <= 1'b1;
    rd_reg(16'h00a3, 8'h00);
    for (int k = 0; k < 7; k++)
      wr_reg(16'h0129 + 16'(k), 8'h10 + 8'(k));
    wr_reg(16'h0123, 8'h77);
    wr_reg(16'h0318, 8'h32);
    wr_reg(16'h00a3, 8'h02);
    @(posedge clk);
    cmp_v({tune, tol, rdiv}, {64'h7716151413121110, 8'h32, 8'h02});
    rd_reg(16'h012f, 8'h16);
    done("registers");
    wr_reg(16'h0000, 8'h01);
    wr_reg(16'h00a1, 8'h02);
    wr_reg(16'h00a0, 8'h03);
    wr_reg(16'h00e0, 8'h00);
    wr_reg(16'h00a2, 8'hc5);
    @(posedge clk);
    cmp_v({stby, src, run, psc, mult}, {1'b0, 2'h1, 1'b1, 3'h4, 6'h05});
    period(0, 8);
    period(2, 6);
    period(1, 4);
    wr_reg(16'h00e0, 8'h02);
    period(1, 8);
    wr_reg(16'h00a2, 8'h05);
    repeat (2) @(posedge clk);
    n = 0;
    for (int k = 0; k < 40; k++)
      @(posedge clk) n += int'(st || yt);
    cmp_n(n, 0);
    cmp_v({run, psc}, {1'b0, 3'h1});
    wr_reg(16'h00a2, 8'h85);
    done("clocks");
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(16'h00e0, {7'h00, k[1]});
      wr_reg(16'h0122, {7'h00, k[0]});
      repeat (2) @(posedge clk iff st);
      a = k[0] ? cq : ci;
      b = k[0] ? ci : cq;
      @(posedge clk);
      cmp_v({fev, fi, fq}, {1'b1, a, k[1] ? b : 12'h000});
    end
    wr_reg(16'h00e0, 8'h00);
    wr_reg(16'h00e8, 8'hf0);
    @(posedge clk iff ft);
    m = mix;
    @(posedge clk);
    cmp_v(mix, 8'(m + 8'hf0));
    wr_reg(16'h00e8, 8'h00);
    done("tuner path");
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(16'h0450, k < 3 ? 8'h00 : (k == 3 ? 8'h01 : 8'h03));
      cable <= c_t[k];
      det <= d_t[k];
      repeat (2) @(posedge clk);
      cmp_v(inv, e_t[k]);
      if (k == 0)
        rd_reg(16'h0444, 8'h01);
    end
    cable <= 1'b0;
    done("inversion");
    wr_reg(16'h0646, 8'h01);
    @(posedge clk);
    cmp_v({poe, con}, 2'b10);
    repeat (4) @(posedge clk);
    wr_reg(16'h0646, 8'h00);
    lvl <= 8'h5a;
    wr_reg(16'h0641, 8'h03);
    @(posedge clk);
    cmp_v({poe, con}, 2'b01);
    repeat (500) @(posedge clk);
    rd_reg(16'h0642, 8'h5a);
    lvl <= 8'h3c;
    n = 0;
    g = 8'h00;
    while (g !== 8'h3c && n < 600)
    begin
      peek(16'h0642, g);
      n += 3;
    end
    lvl <= 8'h66;
    n = 0;
    while (g !== 8'h66 && n < 600)
    begin
      peek(16'h0642, g);
      n += 3;
    end
    cmp_n((n > 180 && n < 204) ? 1 : 0, 1);
    wr_reg(16'h0641, 8'h01);
    lvl <= 8'h11;
    repeat (400) @(posedge clk);
    rd_reg(16'h0642, 8'h66);
    wr_reg(16'h0000, 8'h00);
    @(posedge clk);
    cmp_v({stby, run, poe}, 3'b100);
    done("strength and standby");
    wrap_up();
  end
endmodule : dck_clock_setup_tb_top
`default_nettype wire
